// file: hdl/sldc_pkg.sv
package sldc_pkg;

	// system clock rate
	localparam int SLDC_CLK_HZ = 10_000_000;

	// reference crystal and alternate crystal, in kHz as printed
	localparam int SLDC_REF_KHZ = 7304;
	localparam int SLDC_ALT_KHZ = 1814;

	// local oscillator results, in Hz
	localparam int SLDC_USB_SRC_HZ = 1_826_000;
	localparam int SLDC_USB_LO_HZ = 456_500;
	localparam int SLDC_LSB_LO_HZ = 453_500;

	// divide-by-two stages before and after the source gate
	localparam int SLDC_IN_STAGES = 2;
	localparam int SLDC_OUT_STAGES = 2;

	// sideband select width of the synchroniser
	localparam int SLDC_SYNC_DEPTH = 3;

	// fine tuning oscillator span, in Hz
	localparam int SLDC_FREQ_W = 26;
	localparam logic [SLDC_FREQ_W-1:0] SLDC_FINE_MIN_HZ = 26'h2A7_AE0C;
	localparam logic [SLDC_FREQ_W-1:0] SLDC_FINE_MAX_HZ = 26'h2A7_B5DC;
	localparam logic [SLDC_FREQ_W-1:0] SLDC_FINE_MID_HZ = 26'h2A7_B1F4;
	localparam logic [SLDC_FREQ_W-1:0] SLDC_FINE_STEP_HZ = 26'h000_000A;

	// clarifier offset width, in steps
	localparam int SLDC_OFS_W = 8;

	// sideband mode
	typedef enum logic
	{
		SLDC_LSB = 1'b0,
		SLDC_USB = 1'b1
	} sldc_mode_t;

endpackage : sldc_pkg

// file: hdl/sldc_div2_chain.sv
`timescale 1ns/10ps
module sldc_div2_chain
	import sldc_pkg::*;
#(
	parameter int STAGES = 2
)
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic en_in,
	input wire logic tick_in,
	output logic [STAGES-1:0] count_out,
	output logic carry_out
);

	// elaboration check on the stage count
	if (STAGES < 1)
	begin : g_bad_stages
		$error("sldc_div2_chain needs at least one stage");
	end

	typedef struct packed
	{
		logic [STAGES-1:0] cnt;
		logic carry;
	} sldc_div_t;

	sldc_div_t r;
	sldc_div_t next_r;
	logic [STAGES-1:0] tog;

	// each stage toggles when all stages below it are high
	for (genvar i = 0; i < STAGES; i++)
	begin : g_stage
		if (i == 0)
		begin : g_first
			assign tog[i] = tick_in;
		end
		else
		begin : g_rest
			assign tog[i] = tick_in & (&r.cnt[i-1:0]);
		end
	end

	// disabled stages are held cleared
	always_comb
	begin
		next_r = r;
		next_r.cnt = en_in ? (r.cnt ^ tog) : '0;
		next_r.carry = en_in & tick_in & (&r.cnt);
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			r <= '0;
		end
		else if (ce_in)
		begin
			r <= next_r;
		end
	end

	assign count_out = r.cnt;
	assign carry_out = r.carry;

endmodule : sldc_div2_chain

// file: hdl/sldc_top.sv
`timescale 1ns/10ps
module sldc_top
	import sldc_pkg::*;
#(
	parameter int IN_STAGES = SLDC_IN_STAGES,
	parameter int OUT_STAGES = SLDC_OUT_STAGES
)
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic sideband_sel_in,
	input wire logic ref_tick_in,
	input wire logic alt_tick_in,
	input wire logic clar_load_in,
	input wire logic [SLDC_OFS_W-1:0] clar_offset_in,
	output logic in_div_en_out,
	output logic alt_gate_en_out,
	output logic mod_lo_p_out,
	output logic mod_lo_n_out,
	output logic demod_lo_p_out,
	output logic demod_lo_n_out,
	output logic fine_ref_tick_out,
	output logic [SLDC_FREQ_W-1:0] fine_freq_hz_out,
	output logic fine_at_max_out,
	output logic fine_at_min_out
);

	// elaboration check on divider shape
	if (IN_STAGES != SLDC_IN_STAGES || OUT_STAGES < 1)
	begin : g_bad_shape
		$error("sldc_top divider stages do not give the required ratios");
	end

	typedef struct packed
	{
		logic [SLDC_SYNC_DEPTH-1:0] sb_sync;
		sldc_mode_t mode;
		logic in_div_en;
		logic alt_gate_en;
		logic src_tick;
		logic mod_lo_p;
		logic mod_lo_n;
		logic demod_lo_p;
		logic demod_lo_n;
		logic fine_ref;
		logic [SLDC_FREQ_W-1:0] fine_freq;
		logic at_max;
		logic at_min;
	} sldc_state_t;

	localparam sldc_state_t SLDC_RST = '{
		sb_sync: '0,
		mode: SLDC_LSB,
		in_div_en: 1'b0,
		alt_gate_en: 1'b1,
		src_tick: 1'b0,
		mod_lo_p: 1'b0,
		mod_lo_n: 1'b1,
		demod_lo_p: 1'b0,
		demod_lo_n: 1'b1,
		fine_ref: 1'b0,
		fine_freq: SLDC_FINE_MID_HZ,
		at_max: 1'b0,
		at_min: 1'b0
	};

	localparam logic signed [SLDC_FREQ_W:0] SLDC_MIN_S = $signed({1'b0, SLDC_FINE_MIN_HZ});
	localparam logic signed [SLDC_FREQ_W:0] SLDC_MAX_S = $signed({1'b0, SLDC_FINE_MAX_HZ});

	sldc_state_t r;
	sldc_state_t next_r;
	logic in_carry;
	logic [OUT_STAGES-1:0] out_cnt;
	logic signed [SLDC_FREQ_W:0] ofs_ext;
	logic signed [SLDC_FREQ_W:0] freq_s;

	// input divide-by-two pair on the reference
	sldc_div2_chain #(
		.STAGES(IN_STAGES)
	) u_in_div (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.en_in(r.in_div_en),
		.tick_in(ref_tick_in),
		.count_out(),
		.carry_out(in_carry)
	);

	// final divide-by-two pair after the source gate, always running
	sldc_div2_chain #(
		.STAGES(OUT_STAGES)
	) u_out_div (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.en_in(1'b1),
		.tick_in(r.src_tick),
		.count_out(out_cnt),
		.carry_out()
	);

	// clarifier offset scaled to Hz around the mid frequency
	assign ofs_ext = $signed({{(SLDC_FREQ_W+1-SLDC_OFS_W){clar_offset_in[SLDC_OFS_W-1]}},
		clar_offset_in});
	assign freq_s = (SLDC_FREQ_W+1)'($signed({1'b0, SLDC_FINE_MID_HZ})
		+ ofs_ext * $signed({1'b0, SLDC_FINE_STEP_HZ}));

	always_comb
	begin
		next_r = r;
		// sideband select synchroniser, change taken once stages two and three agree
		next_r.sb_sync = {r.sb_sync[SLDC_SYNC_DEPTH-2:0], sideband_sel_in};
		if (r.sb_sync[1] == r.sb_sync[2])
		begin
			next_r.mode = r.sb_sync[2] ? SLDC_USB : SLDC_LSB;
		end
		next_r.in_div_en = (r.mode == SLDC_USB);
		next_r.alt_gate_en = (r.mode == SLDC_LSB);
		// source gate picks reference over four in USB, gated alternate tick in LSB
		if (r.mode == SLDC_USB)
		begin
			next_r.src_tick = in_carry;
		end
		else
		begin
			next_r.src_tick = alt_tick_in & r.alt_gate_en;
		end
		// one balanced output to both mixers
		next_r.mod_lo_p = out_cnt[OUT_STAGES-1];
		next_r.mod_lo_n = ~out_cnt[OUT_STAGES-1];
		next_r.demod_lo_p = out_cnt[OUT_STAGES-1];
		next_r.demod_lo_n = ~out_cnt[OUT_STAGES-1];
		next_r.fine_ref = ref_tick_in;
		if (clar_load_in)
		begin
			if (freq_s >= SLDC_MAX_S)
			begin
				next_r.fine_freq = SLDC_FINE_MAX_HZ;
				next_r.at_max = 1'b1;
				next_r.at_min = 1'b0;
			end
			else if (freq_s <= SLDC_MIN_S)
			begin
				next_r.fine_freq = SLDC_FINE_MIN_HZ;
				next_r.at_max = 1'b0;
				next_r.at_min = 1'b1;
			end
			else
			begin
				next_r.fine_freq = freq_s[SLDC_FREQ_W-1:0];
				next_r.at_max = 1'b0;
				next_r.at_min = 1'b0;
			end
		end
	end

	// state register, frozen while the clock enable is low
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			r <= SLDC_RST;
		end
		else if (ce_in)
		begin
			r <= next_r;
		end
	end

	// outputs straight from the state register
	assign in_div_en_out = r.in_div_en;
	assign alt_gate_en_out = r.alt_gate_en;
	assign mod_lo_p_out = r.mod_lo_p;
	assign mod_lo_n_out = r.mod_lo_n;
	assign demod_lo_p_out = r.demod_lo_p;
	assign demod_lo_n_out = r.demod_lo_n;
	assign fine_ref_tick_out = r.fine_ref;
	assign fine_freq_hz_out = r.fine_freq;
	assign fine_at_max_out = r.at_max;
	assign fine_at_min_out = r.at_min;

endmodule : sldc_top

// file: sim/sldc_monitor.sv
`timescale 1ns/10ps
module sldc_monitor
	import sldc_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic ref_tick_in,
	input wire logic clar_load_in,
	input wire logic [SLDC_OFS_W-1:0] clar_offset_in,
	input wire logic in_div_en_out,
	input wire logic alt_gate_en_out,
	input wire logic mod_lo_p_out,
	input wire logic mod_lo_n_out,
	input wire logic demod_lo_p_out,
	input wire logic demod_lo_n_out,
	input wire logic fine_ref_tick_out,
	input wire logic [SLDC_FREQ_W-1:0] fine_freq_hz_out,
	input wire logic fine_at_max_out,
	input wire logic fine_at_min_out
);
	default clocking dc @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	property p_mode; in_div_en_out != alt_gate_en_out; endproperty
	a_mode: assert property (p_mode) else $error("source gates disagree");
	property p_bal; mod_lo_p_out != mod_lo_n_out; endproperty
	a_bal: assert property (p_bal) else $error("lo pair not balanced");
	property p_same; {mod_lo_p_out, mod_lo_n_out} == {demod_lo_p_out, demod_lo_n_out}; endproperty
	a_same: assert property (p_same) else $error("mixer lo differ");
	property p_ref; $past(rst_n_in) && $past(ce_in) |-> fine_ref_tick_out == $past(ref_tick_in);
	endproperty
	a_ref: assert property (p_ref) else $error("fine reference tick wrong");
	property p_load; clar_load_in && ce_in && $signed(clar_offset_in) inside {[-100:100]} |=>
		fine_freq_hz_out == 26'(int'(SLDC_FINE_MID_HZ) + 10 * $signed($past(clar_offset_in)));
	endproperty
	a_load: assert property (p_load) else $error("fine frequency wrong");
	property p_hold; !clar_load_in |=> $stable(fine_freq_hz_out); endproperty
	a_hold: assert property (p_hold) else $error("fine frequency moved");
	property p_max; fine_at_max_out |-> fine_freq_hz_out == SLDC_FINE_MAX_HZ && !fine_at_min_out;
	endproperty
	a_max: assert property (p_max) else $error("max flag wrong");
	property p_min; fine_at_min_out |-> fine_freq_hz_out == SLDC_FINE_MIN_HZ; endproperty
	a_min: assert property (p_min) else $error("min flag wrong");
endmodule : sldc_monitor

bind sldc_top sldc_monitor mon (.*);

// file: sim/sldc_host_model.sv
`timescale 1ns/10ps
module sldc_host_model
	import sldc_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic up_in,
	input wire logic dn_in,
	input wire logic chan_in,
	input wire logic [7:0] lim_in,
	output logic clar_load_out = 1'h0,
	output logic [SLDC_OFS_W-1:0] clar_offset_out = 8'h00,
	output logic beep_out = 1'h0
);
	logic signed [7:0] ofs = 8'h00;
	always @(posedge clk_in)
	begin
		if (!rst_n_in || chan_in)
			ofs = 8'h00;
		else if (up_in && ofs < $signed(lim_in))
			ofs = ofs + 8'h01;
		else if (dn_in && ofs > -$signed(lim_in))
			ofs = ofs - 8'h01;
		clar_load_out <= rst_n_in && (up_in || dn_in || chan_in);
		clar_offset_out <= ofs;
		beep_out <= ofs == $signed(lim_in) || ofs == -$signed(lim_in);
	end
endmodule : sldc_host_model

// file: sim/testbench.sv
`timescale 1ns/10ps
module testbench;
	import sldc_pkg::*;
	logic clk_in = 1'h0;
	logic rst_n_in = 1'h0;
	logic sel = 1'h0;
	logic up = 1'h0;
	logic dn = 1'h0;
	logic chan = 1'h0;
	logic ce = 1'h1;
	logic [7:0] lim = 8'h05;
	logic ld, beep, in_en, alt_en, mp, mn, fref, at_max, at_min;
	logic [SLDC_OFS_W-1:0] ofs;
	logic [SLDC_FREQ_W-1:0] freq;
	int errors = 0;
	int total_checks = 0;
	// clock of 100 ns
	always #50 clk_in = ~clk_in;
	sldc_host_model host (.clk_in(clk_in), .rst_n_in(rst_n_in), .up_in(up), .dn_in(dn),
		.chan_in(chan), .lim_in(lim), .clar_load_out(ld), .clar_offset_out(ofs), .beep_out(beep));
	sldc_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce), .sideband_sel_in(sel),
		.ref_tick_in(1'h1), .alt_tick_in(1'h1), .clar_load_in(ld), .clar_offset_in(ofs),
		.in_div_en_out(in_en), .alt_gate_en_out(alt_en), .mod_lo_p_out(mp), .mod_lo_n_out(mn),
		.demod_lo_p_out(), .demod_lo_n_out(), .fine_ref_tick_out(fref),
		.fine_freq_hz_out(freq), .fine_at_max_out(at_max), .fine_at_min_out(at_min));
	task conclude;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED at %0t: got %0h want %0h", $time, got, exp);
		end
	endtask : chk
	task timeout;
		errors++;
		$display("CHECK FAILED at %0t: wait ran out", $time);
		conclude();
	endtask : timeout
	// cycles up to the next rising lo edge
	task rise(output int n);
		logic last;
		n = 1;
		last = mp;
		@(negedge clk_in);
		while (!(mp === 1'h1 && last === 1'h0))
		begin
			last = mp;
			@(negedge clk_in);
			n++;
			if (n > 64)
				timeout();
		end
	endtask : rise
	task period(input int exp);
		int n;
		rise(n);
		rise(n);
		chk(n, exp);
	endtask : period
	// k clarifier steps, two cycles apart
	task step(input logic u, input int k);
		repeat (k)
		begin
			@(posedge clk_in);
			up <= u;
			dn <= !u;
			@(posedge clk_in);
			up <= 1'h0;
			dn <= 1'h0;
		end
		repeat (3) @(posedge clk_in);
		@(negedge clk_in);
	endtask : step
	task t_lsb;
		period(4);
		$display("test lsb done");
	endtask : t_lsb
	task t_usb;
		int n;
		n = 0;
		@(posedge clk_in);
		sel <= 1'h1;
		while (in_en !== 1'h1)
		begin
			@(negedge clk_in);
			n++;
			if (n > 8)
				timeout();
		end
		chk(alt_en, 0);
		period(16);
		$display("test usb done");
	endtask : t_usb
	task t_clar;
		step(1'h1, 7);
		chk(freq, SLDC_FINE_MID_HZ + 50);
		chk(beep, 1);
		@(posedge clk_in);
		chan <= 1'h1;
		lim <= 8'h78;
		@(posedge clk_in);
		chan <= 1'h0;
		step(1'h0, 101);
		chk({freq, at_min}, {SLDC_FINE_MIN_HZ, 1'h1});
		step(1'h1, 202);
		chk({freq, at_max}, {SLDC_FINE_MAX_HZ, 1'h1});
		$display("test clarifier done");
	endtask : t_clar
	// clock enable low freezes dividers and frequency
	task t_freeze;
		logic hold;
		@(posedge clk_in);
		ce <= 1'h0;
		repeat (2) @(posedge clk_in);
		@(negedge clk_in);
		hold = mp;
		repeat (24) @(negedge clk_in);
		chk(mp, hold);
		chk(freq, SLDC_FINE_MAX_HZ);
		@(posedge clk_in);
		ce <= 1'h1;
		period(16);
		$display("test freeze done");
	endtask : t_freeze
	// reset values, then the scenarios
	initial
	begin
		repeat (19) @(posedge clk_in);
		@(negedge clk_in);
		chk({in_en, alt_en, mp, mn, fref, at_max, at_min}, 32'h0000_0028);
		chk(freq, SLDC_FINE_MID_HZ);
		@(posedge clk_in);
		rst_n_in <= 1'h1;
		t_lsb();
		t_usb();
		t_clar();
		t_freeze();
		conclude();
	end
endmodule : testbench
